//--- hdl/sevr_defines.svh
// constants of the status and event reporting block
//
// Function
// - request service bit is set when any enabled status byte summary bit is set
// - a rising request service bit raises the bus service request line
// - every query answers the binary weighted sum of eight bits as decimal
// - only the enable masks are writable; all other status registers read only
// - condition registers show live status, never latched, never cleared
// - event register clears on its own read query, clear-status or power-up
// - every enable mask clears on writing zero and at power-up
// - status byte has no clear; summary bits follow their event registers
// - standard event mask write and query; standard event read then clear
// - standard event bit 7 flags an off-to-on power transition
// - standard event bit 5 flags a command that could not be interpreted
// - standard event bit 4 flags a command beyond the instrument capabilities
// - standard event bit 2 flags response data lost to a full output queue
// - after operation-complete command, bit 0 sets once pending work finishes
// - operation mask write and query, event read-clear, condition query
// - operation event bit 7 flags failed sensor processor communication
// - operation event bit 6 flags missing or corrupted calibration
// - operation event bit 5 sets whenever automatic tuning is not running
// - operation event bit 4 sets when a new sensor reading arrives
// - operation event bits 3 and 2 flag loop one and loop two ramp done
// - operation bit 1 flags overload; bit 0 flags visible input alarm
// - event bits latch, ignore repeats, and hold until the register clears
// - status byte: operation summary 7, request 6, standard summary 5, message 4
`ifndef SEVR_DEFINES_SVH
`define SEVR_DEFINES_SVH

`define SEVR_W           8
`define SEVR_MASK_RST    8'h00
`define SEVR_EVENT_RST   8'h00

`define SEVR_STD_PON     7
`define SEVR_STD_CME     5
`define SEVR_STD_EXE     4
`define SEVR_STD_QYE     2
`define SEVR_STD_OPC     0

`define SEVR_OP_COM      7
`define SEVR_OP_CAL      6
`define SEVR_OP_TUNE     5
`define SEVR_OP_SAMPLE   4
`define SEVR_OP_LOOP_ONE_RAMP_FINISHED    3
`define SEVR_OP_LOOP_TWO_RAMP_FINISHED    2
`define SEVR_OP_OVER     1
`define SEVR_OP_ALARM    0

`define SEVR_STB_OSB     7
`define SEVR_STB_RQS     6
`define SEVR_STB_ESB     5
`define SEVR_STB_MAV     4

`define SEVR_DEC_HUNDRED 8'd100
`define SEVR_DEC_TEN     8'd10

`endif

//--- hdl/sevr_pkg.sv
// types of the status and event reporting block
package sevr_pkg;
  typedef enum logic [3:0] {
    SEVR_CMD_STD_MASK_WR,
    SEVR_CMD_STD_MASK_RD,
    SEVR_CMD_STD_EVENT_RD,
    SEVR_CMD_OP_MASK_WR,
    SEVR_CMD_OP_MASK_RD,
    SEVR_CMD_OP_EVENT_RD,
    SEVR_CMD_OP_COND_RD,
    SEVR_CMD_SRQ_MASK_WR,
    SEVR_CMD_SRQ_MASK_RD,
    SEVR_CMD_STB_RD,
    SEVR_CMD_CLEAR_STATUS,
    SEVR_CMD_OPC,
    SEVR_CMD_SERIAL_POLL
  } sevr_cmd_t;

  typedef logic [7:0] sevr_byte_t;
endpackage

//--- hdl/sevr_set_if.sv
// signals between the top and one event register set
interface sevr_set_if;
  logic [7:0] set_bits;
  logic       clear;
  logic       mask_we;
  logic [7:0] mask_wdata;
  logic [7:0] event_bits;
  logic [7:0] mask_bits;
  logic       summary;

  modport owner (output set_bits, output clear, output mask_we, output mask_wdata,
                 input event_bits, input mask_bits, input summary);
  modport set (input set_bits, input clear, input mask_we, input mask_wdata,
               output event_bits, output mask_bits, output summary);
endinterface

//--- hdl/sevr_event_set.sv
// one latched event register with its enable mask and summary
`include "sevr_defines.svh"
module sevr_event_set
  import sevr_pkg::*;
(
  input  wire logic clk,     // block clock
  input  wire logic rst_n,   // synchronous reset, low
  sevr_set_if.set   bus      // set control and state
);
  sevr_byte_t event_q;
  sevr_byte_t mask_q;

  genvar i;
  generate
    for (i = 0; i < `SEVR_W; i++) begin : g_bit
      // set beats clear; a set bit ignores further events
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          event_q[i] <= 1'b0;
        end else if (bus.set_bits[i]) begin
          event_q[i] <= 1'b1;
        end else if (bus.clear) begin
          event_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `SEVR_MASK_RST;
    end else if (bus.mask_we) begin
      mask_q <= bus.mask_wdata;
    end
  end

  assign bus.event_bits = event_q;
  assign bus.mask_bits  = mask_q;
  assign bus.summary    = |(event_q & mask_q);
endmodule

//--- hdl/sevr_top.sv
// status byte, service request and command handling of the status block
`include "sevr_defines.svh"
module sevr_top
  import sevr_pkg::*;
(
  input  wire logic        CLOCK,                   // 25 MHz clock
  input  wire logic        RST_N,                   // synchronous reset, low
  input  wire logic        CMD_VALID,               // command strobe
  input  wire logic [3:0]  CMD_CODE,                // command code
  input  wire logic [7:0]  CMD_VALUE,               // mask value as binary weight
  output logic             RSP_VALID,               // query answer strobe
  output logic [7:0]       RSP_VALUE,               // answer, binary weighted
  output logic [11:0]      RSP_DECIMAL,             // answer, three decimal digits
  output logic             CMD_ILLEGAL,             // unknown command code seen
  input  wire logic        POWER_ON_EVENT,          // off-to-on transition
  input  wire logic        CMD_ERROR_EVENT,         // command not interpretable
  input  wire logic        EXEC_ERROR_EVENT,        // command beyond capability
  input  wire logic        QUERY_ERROR_EVENT,       // answer lost, queue full
  input  wire logic        OPS_PENDING,             // operations still running
  input  wire logic        SENSOR_LINK_FAIL,        // sensor processor silent
  input  wire logic        CAL_INVALID,             // calibration missing or bad
  input  wire logic        TUNING_IDLE,             // autotune not running
  input  wire logic        FRESH_SENSOR_SAMPLE,     // new reading available
  input  wire logic        LOOP_ONE_RAMP_FINISHED,  // loop one ramp done
  input  wire logic        LOOP_TWO_RAMP_FINISHED,  // loop two ramp done
  input  wire logic        SENSOR_OVERRANGE,        // reading in overload
  input  wire logic        INPUT_ALARM,             // an input in alarm
  input  wire logic        ALARM_VISIBLE,           // alarm visible setting
  input  wire logic        MSG_AVAILABLE,           // output buffer not empty
  output logic [7:0]       STATUS_BYTE,             // live status byte
  output logic             OPERATION_SUMMARY_BIT,   // operation set summary
  output logic             EVENT_SUMMARY_BIT,       // standard set summary
  output logic             MASTER_SUMMARY,          // request service bit
  output logic             SRQ_ASSERT               // bus service request
);
  // one carrier per event register set
  sevr_set_if std_if ();
  sevr_set_if op_if ();

  sevr_cmd_t  cmd;
  logic       cmd_known;
  sevr_byte_t op_cond;
  sevr_byte_t std_set;
  sevr_byte_t srq_mask_q;
  sevr_byte_t stb;
  logic       mss;
  logic       mss_q;
  logic       rqs_q;
  logic       opc_armed_q;
  logic       opc_done;
  logic       is_query;
  sevr_byte_t rsp_d;
  logic       rsp_valid_q;
  sevr_byte_t rsp_value_q;
  logic [11:0] rsp_decimal_q;
  logic       illegal_q;
  // one strobe per state-changing command
  logic       wr_std_mask;
  logic       wr_op_mask;
  logic       wr_srq_mask;
  logic       rd_std_event;
  logic       rd_op_event;
  logic       clear_status;
  logic       arm_opc;
  logic       serial_poll;
  logic       bad_code;

  // codes past the last command decode to nothing
  always_comb begin
    cmd       = SEVR_CMD_STD_MASK_WR;
    cmd_known = 1'b0;
    if (CMD_CODE <= 4'(SEVR_CMD_SERIAL_POLL)) begin
      cmd       = sevr_cmd_t'(CMD_CODE);
      cmd_known = CMD_VALID;
    end
  end

  // command strobes, only for a known code with the strobe high; bad_code for an unknown code with the strobe high
  always_comb begin
    wr_std_mask  = cmd_known && cmd == SEVR_CMD_STD_MASK_WR;
    wr_op_mask   = cmd_known && cmd == SEVR_CMD_OP_MASK_WR;
    wr_srq_mask  = cmd_known && cmd == SEVR_CMD_SRQ_MASK_WR;
    rd_std_event = cmd_known && cmd == SEVR_CMD_STD_EVENT_RD;
    rd_op_event  = cmd_known && cmd == SEVR_CMD_OP_EVENT_RD;
    clear_status = cmd_known && cmd == SEVR_CMD_CLEAR_STATUS;
    arm_opc      = cmd_known && cmd == SEVR_CMD_OPC;
    serial_poll  = cmd_known && cmd == SEVR_CMD_SERIAL_POLL;
    bad_code     = CMD_VALID && !cmd_known;
  end

  // live operation conditions, never latched
  always_comb begin
    op_cond                  = 8'h00;
    op_cond[`SEVR_OP_COM]    = SENSOR_LINK_FAIL;
    op_cond[`SEVR_OP_CAL]    = CAL_INVALID;
    op_cond[`SEVR_OP_TUNE]   = TUNING_IDLE;
    op_cond[`SEVR_OP_SAMPLE] = FRESH_SENSOR_SAMPLE;
    op_cond[`SEVR_OP_LOOP_ONE_RAMP_FINISHED]  = LOOP_ONE_RAMP_FINISHED;
    op_cond[`SEVR_OP_LOOP_TWO_RAMP_FINISHED]  = LOOP_TWO_RAMP_FINISHED;
    op_cond[`SEVR_OP_OVER]   = SENSOR_OVERRANGE;
    op_cond[`SEVR_OP_ALARM]  = INPUT_ALARM & ALARM_VISIBLE;
  end

  // operation complete arming
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      opc_armed_q <= 1'b0;
    end else if (arm_opc) begin
      opc_armed_q <= 1'b1;
    end else if (opc_done) begin
      opc_armed_q <= 1'b0;
    end
  end
  // done once nothing is pending; the arm drops on the same edge
  assign opc_done = opc_armed_q & ~OPS_PENDING;

  // standard event sources, bit 0 from the operation-complete arm
  always_comb begin
    std_set                 = 8'h00;
    std_set[`SEVR_STD_PON]  = POWER_ON_EVENT;
    std_set[`SEVR_STD_CME]  = CMD_ERROR_EVENT;
    std_set[`SEVR_STD_EXE]  = EXEC_ERROR_EVENT;
    std_set[`SEVR_STD_QYE]  = QUERY_ERROR_EVENT;
    std_set[`SEVR_STD_OPC]  = opc_done;
  end

  // drive of the standard event set
  always_comb begin
    std_if.set_bits   = std_set;
    std_if.clear      = rd_std_event || clear_status;
    std_if.mask_we    = wr_std_mask;
    std_if.mask_wdata = CMD_VALUE;
  end

  // drive of the operation event set
  always_comb begin
    op_if.set_bits    = op_cond;
    op_if.clear       = rd_op_event || clear_status;
    op_if.mask_we     = wr_op_mask;
    op_if.mask_wdata  = CMD_VALUE;
  end

  // standard event set
  sevr_event_set u_std_set (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .bus   (std_if)
  );

  // operation event set
  sevr_event_set u_op_set (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .bus   (op_if)
  );

  // service request mask; its bit 6 never feeds the summary
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      srq_mask_q <= `SEVR_MASK_RST;
    end else if (wr_srq_mask) begin
      srq_mask_q <= CMD_VALUE;
    end
  end

  // status byte is combinational, so it follows its event registers
  always_comb begin
    stb                = 8'h00;
    stb[`SEVR_STB_OSB] = op_if.summary;
    stb[`SEVR_STB_ESB] = std_if.summary;
    stb[`SEVR_STB_MAV] = MSG_AVAILABLE;
    mss                = |(stb & srq_mask_q);
    stb[`SEVR_STB_RQS] = mss;
  end

  // summary one edge back, resets to its idle level so no false rise
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mss_q <= 1'b0;
    end else begin
      mss_q <= mss;
    end
  end

  // request latch: rising summary sets, serial poll or idle summary clears
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rqs_q <= 1'b0;
    end else if (mss && !mss_q) begin
      rqs_q <= 1'b1;
    end else if (!mss || serial_poll) begin
      rqs_q <= 1'b0;
    end
  end

  // answer select; event reads return the value before clearing
  always_comb begin
    rsp_d    = 8'h00;
    is_query = 1'b0;
    if (cmd_known) begin
      unique case (cmd)
        SEVR_CMD_STD_MASK_RD: begin
          rsp_d    = std_if.mask_bits;
          is_query = 1'b1;
        end
        SEVR_CMD_STD_EVENT_RD: begin
          rsp_d    = std_if.event_bits;
          is_query = 1'b1;
        end
        SEVR_CMD_OP_MASK_RD: begin
          rsp_d    = op_if.mask_bits;
          is_query = 1'b1;
        end
        SEVR_CMD_OP_EVENT_RD: begin
          rsp_d    = op_if.event_bits;
          is_query = 1'b1;
        end
        SEVR_CMD_OP_COND_RD: begin
          rsp_d    = op_cond;
          is_query = 1'b1;
        end
        SEVR_CMD_SRQ_MASK_RD: begin
          rsp_d    = srq_mask_q;
          is_query = 1'b1;
        end
        SEVR_CMD_STB_RD: begin
          rsp_d    = stb;
          is_query = 1'b1;
        end
        SEVR_CMD_SERIAL_POLL: begin
          rsp_d                = stb;
          rsp_d[`SEVR_STB_RQS] = rqs_q;
          is_query             = 1'b1;
        end
        SEVR_CMD_STD_MASK_WR,
        SEVR_CMD_OP_MASK_WR,
        SEVR_CMD_SRQ_MASK_WR,
        SEVR_CMD_CLEAR_STATUS,
        SEVR_CMD_OPC: begin
          rsp_d    = 8'h00;
          is_query = 1'b0;
        end
      endcase
    end
  end

  // three decimal digits of an eight-bit value
  function automatic logic [11:0] to_decimal(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = v / `SEVR_DEC_HUNDRED;
    t = (v % `SEVR_DEC_HUNDRED) / `SEVR_DEC_TEN;
    o = v % `SEVR_DEC_TEN;
    return {h[3:0], t[3:0], o[3:0]};
  endfunction

  // answer strobe, one cycle after each query
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= is_query;
    end
  end

  // binary answer holds until the next query
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rsp_value_q <= 8'h00;
    end else if (is_query) begin
      rsp_value_q <= rsp_d;
    end
  end

  // decimal digits of the same answer
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rsp_decimal_q <= 12'h000;
    end else if (is_query) begin
      rsp_decimal_q <= to_decimal(rsp_d);
    end
  end

  // unknown codes change nothing, they only raise a one-cycle flag
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= bad_code;
    end
  end

  // port drive
  assign RSP_VALID             = rsp_valid_q;
  assign RSP_VALUE             = rsp_value_q;
  assign RSP_DECIMAL           = rsp_decimal_q;
  assign CMD_ILLEGAL           = illegal_q;
  assign STATUS_BYTE           = stb;
  assign OPERATION_SUMMARY_BIT = op_if.summary;
  assign EVENT_SUMMARY_BIT     = std_if.summary;
  assign MASTER_SUMMARY        = mss;
  assign SRQ_ASSERT            = rqs_q;
endmodule

//--- test/sevr_ctrl_model.sv
// bus controller model issuing status commands
module sevr_ctrl_model
  import sevr_pkg::*;
(
  input  wire logic       clk,        // block clock
  output logic            cmd_valid,  // command strobe
  output logic [3:0]      cmd_code,   // command code
  output sevr_byte_t      cmd_value   // mask value, binary weighted
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_value = 8'h00;
  end
  // one command, held up to the edge that takes it
  task automatic issue(input logic [3:0] code, input sevr_byte_t value);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_value = value;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_value = ~value;
  endtask
endmodule

//--- test/sevr_top_chk.sv
// assertions on the ports of the status block top
module sevr_top_chk
  import sevr_pkg::*;
(
  input wire logic       CLOCK,                  // clock
  input wire logic       RST_N,                  // reset, low
  input wire logic       CMD_VALID,              // command strobe
  input wire logic [3:0] CMD_CODE,               // command code
  input wire logic       RSP_VALID,              // answer strobe
  input wire logic [7:0] RSP_VALUE,              // answer
  input wire logic [11:0] RSP_DECIMAL,           // answer digits
  input wire logic       CMD_ILLEGAL,            // unknown code
  input wire logic       POWER_ON_EVENT,         // power on
  input wire logic       CMD_ERROR_EVENT,        // command error
  input wire logic       EXEC_ERROR_EVENT,       // execution error
  input wire logic       QUERY_ERROR_EVENT,      // query error
  input wire logic       OPS_PENDING,            // work pending
  input wire logic       MSG_AVAILABLE,          // message waiting
  input wire logic [7:0] STATUS_BYTE,            // status byte
  input wire logic       OPERATION_SUMMARY_BIT,  // op summary
  input wire logic       EVENT_SUMMARY_BIT,      // std summary
  input wire logic       MASTER_SUMMARY,         // request service bit
  input wire logic       SRQ_ASSERT              // service request line
);
  logic is_query;
  assign is_query = CMD_VALID &&
                    (CMD_CODE inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc});
  function automatic logic [11:0] bcd(input logic [7:0] v);
    logic [7:0] h, t, o;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    o = v % 8'd10;
    return {h[3:0], t[3:0], o[3:0]};
  endfunction
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_esr;
    CMD_VALID && CMD_CODE == 4'h2;
  endsequence
  sequence s_pon;
    POWER_ON_EVENT ##1 s_esr;
  endsequence
  property p_map;
    STATUS_BYTE == {OPERATION_SUMMARY_BIT, MASTER_SUMMARY, EVENT_SUMMARY_BIT, MSG_AVAILABLE, 4'h0};
  endproperty
  property p_query; is_query |=> RSP_VALID; endproperty
  property p_quiet; !is_query |=> !RSP_VALID; endproperty
  property p_dec; RSP_VALID |-> RSP_DECIMAL == bcd(RSP_VALUE); endproperty
  property p_illegal; CMD_VALID && CMD_CODE > 4'hc |=> CMD_ILLEGAL; endproperty
  property p_srq_rise; $rose(MASTER_SUMMARY) |=> SRQ_ASSERT; endproperty
  property p_srq_drop; !MASTER_SUMMARY |=> !SRQ_ASSERT; endproperty
  property p_stb_read;
    CMD_VALID && CMD_CODE == 4'h9 |=> RSP_VALUE == $past(STATUS_BYTE);
  endproperty
  property p_pon; s_pon |=> RSP_VALUE[7]; endproperty
  property p_esb_clear;
    s_esr and (OPS_PENDING && !POWER_ON_EVENT && !CMD_ERROR_EVENT && !EXEC_ERROR_EVENT
      && !QUERY_ERROR_EVENT) |=> !EVENT_SUMMARY_BIT;
  endproperty
  a_map: assert property (p_map) else $error("status byte map wrong");
  a_query: assert property (p_query) else $error("query not answered");
  a_quiet: assert property (p_quiet) else $error("answer without query");
  a_dec: assert property (p_dec) else $error("decimal answer wrong");
  a_illegal: assert property (p_illegal) else $error("illegal code not flagged");
  a_srq_rise: assert property (p_srq_rise) else $error("service request missed");
  a_srq_drop: assert property (p_srq_drop) else $error("service request stuck");
  a_stb_read: assert property (p_stb_read) else $error("status byte read wrong");
  a_pon: assert property (p_pon) else $error("power on bit missing");
  a_esb_clear: assert property (p_esb_clear) else $error("summary kept after read");
endmodule

//--- test/test_status_event_reporting.sv
// self-checking bench of the status block
bind sevr_top sevr_top_chk u_sevr_top_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
  .CMD_CODE(CMD_CODE), .RSP_VALID(RSP_VALID), .RSP_VALUE(RSP_VALUE), .RSP_DECIMAL(RSP_DECIMAL),
  .CMD_ILLEGAL(CMD_ILLEGAL), .POWER_ON_EVENT(POWER_ON_EVENT), .CMD_ERROR_EVENT(CMD_ERROR_EVENT),
  .EXEC_ERROR_EVENT(EXEC_ERROR_EVENT), .QUERY_ERROR_EVENT(QUERY_ERROR_EVENT),
  .OPS_PENDING(OPS_PENDING), .MSG_AVAILABLE(MSG_AVAILABLE), .STATUS_BYTE(STATUS_BYTE),
  .OPERATION_SUMMARY_BIT(OPERATION_SUMMARY_BIT), .EVENT_SUMMARY_BIT(EVENT_SUMMARY_BIT),
  .MASTER_SUMMARY(MASTER_SUMMARY), .SRQ_ASSERT(SRQ_ASSERT));
module test_status_event_reporting
  import sevr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, rst_n, cmd_valid, opsp, vis, msg;
  logic [3:0] cmd_code;
  sevr_byte_t cmd_value, std_in, op_in, rsp_value, stb, e;
  logic       rsp_valid, srq;
  logic [31:0] rng = 32'h00005008;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;
  sevr_byte_t exp_q[$];
  logic [3:0] wr_c[3] = '{4'h0, 4'h3, 4'h7};
  logic [3:0] rd_c[3] = '{4'h1, 4'h4, 4'h8};
  int         std_bits[4] = '{7, 5, 4, 2};
  sevr_ctrl_model u_sevr_ctrl_model (.clk(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_value(cmd_value));
  sevr_top u_sevr_top (.CLOCK(clock), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .CMD_VALUE(cmd_value), .RSP_VALID(rsp_valid), .RSP_VALUE(rsp_value), .RSP_DECIMAL(),
    .CMD_ILLEGAL(), .POWER_ON_EVENT(std_in[7]), .CMD_ERROR_EVENT(std_in[5]),
    .EXEC_ERROR_EVENT(std_in[4]), .QUERY_ERROR_EVENT(std_in[2]), .OPS_PENDING(opsp),
    .SENSOR_LINK_FAIL(op_in[7]), .CAL_INVALID(op_in[6]), .TUNING_IDLE(op_in[5]),
    .FRESH_SENSOR_SAMPLE(op_in[4]), .LOOP_ONE_RAMP_FINISHED(op_in[3]),
    .LOOP_TWO_RAMP_FINISHED(op_in[2]), .SENSOR_OVERRANGE(op_in[1]), .INPUT_ALARM(op_in[0]),
    .ALARM_VISIBLE(vis), .MSG_AVAILABLE(msg), .STATUS_BYTE(stb), .OPERATION_SUMMARY_BIT(),
    .EVENT_SUMMARY_BIT(), .MASTER_SUMMARY(), .SRQ_ASSERT(srq));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic final_report();
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic query(input logic [3:0] c, input sevr_byte_t expv);
    exp_q.push_back(expv);
    u_sevr_ctrl_model.issue(c, 8'h00);
  endtask
  task automatic std_event(input int idx);
    @(posedge clock);
    #1 std_in[idx] = 1'b1;
    fork
      query(4'h2, 8'h01 << idx);
      begin @(posedge clock); #1 std_in[idx] = 1'b0; end
    join
    query(4'h2, 8'h00);
  endtask
  always #20 clock = ~clock;
  always @(negedge clock) begin
    if (rsp_valid === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
      check(rsp_value, e);
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    sevr_byte_t v;
    clock = 1'b0; rst_n = 1'b0; opsp = 1'b1; vis = 1'b0; msg = 1'b0;
    std_in = 8'h00; op_in = 8'h00;
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    foreach (rd_c[i]) query(rd_c[i], 8'h00);
    query(4'h9, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = 8'(rnd());
      if (i == 2) v &= 8'hbf;
      u_sevr_ctrl_model.issue(wr_c[i], v);
      query(rd_c[i], v);
      u_sevr_ctrl_model.issue(wr_c[i], 8'h00);
      query(rd_c[i], 8'h00);
    end
    foreach (std_bits[k]) std_event(std_bits[k]);
    for (int i = 0; i < 3; i++) begin
      v = 8'(rnd());
      @(posedge clock);
      #1 op_in = v; vis = rng[9];
      query(4'h6, v & {7'h7f, vis});
      op_in = 8'h00;
      query(4'h6, 8'h00);
      query(4'h5, v & {7'h7f, vis});
      query(4'h5, 8'h00);
    end
    u_sevr_ctrl_model.issue(4'hb, 8'h00);
    repeat (4) @(posedge clock);
    query(4'h2, 8'h00);
    opsp = 1'b0;
    query(4'h2, 8'h01);
    opsp = 1'b1;
    @(posedge clock);
    #1 std_in = 8'h20; op_in = 8'hff;
    @(posedge clock);
    #1 std_in = 8'h00; op_in = 8'h00;
    u_sevr_ctrl_model.issue(4'ha, 8'h00);
    query(4'h2, 8'h00);
    query(4'h5, 8'h00);
    u_sevr_ctrl_model.issue(4'h0, 8'h20);
    u_sevr_ctrl_model.issue(4'h7, 8'h20);
    @(posedge clock);
    #1 std_in[5] = 1'b1;
    @(posedge clock);
    #1 std_in[5] = 1'b0;
    repeat (2) @(posedge clock);
    #1 check({7'h00, srq}, 8'h01);
    check(stb, 8'h60);
    query(4'hc, 8'h60);
    check({7'h00, srq}, 8'h00);
    query(4'h9, 8'h60);
    query(4'h2, 8'h20);
    check(stb, 8'h00);
    msg = 1'b1;
    #1 check(stb, 8'h10);
    for (int c = 13; c < 16; c++) u_sevr_ctrl_model.issue(c[3:0], 8'h00);
    u_sevr_ctrl_model.issue(4'h3, 8'h10);
    @(posedge clock);
    #1 op_in = 8'h10;
    @(posedge clock);
    #1 op_in = 8'h00;
    check(stb, 8'h90);
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    query(4'h4, 8'h00);
    query(4'h1, 8'h00);
    query(4'h8, 8'h00);
    query(4'h5, 8'h00);
    check(stb, 8'h10);
    repeat (3) @(posedge clock);
    final_report();
  end
endmodule
